//--- i2c_slave_pkg.sv
// constants, types and states shared by the two-wire register slave
package i2c_slave_pkg;

  // slave address layout
  localparam logic [3:0]  ADDR_FIXED_HI = 4'hb;    // upper four address bits, 1011
  localparam logic [1:0]  PIN_LOW       = 2'h0;    // three-level strap codes
  localparam logic [1:0]  PIN_OPEN      = 2'h1;
  localparam logic [1:0]  PIN_HIGH      = 2'h2;
  localparam logic [3:0]  STRAP_LEVELS  = 4'h3;    // levels per strap pin
  localparam logic [3:0]  STRAP_OTHER   = 4'h8;    // both high: other port selected

  // register pointer and update control
  localparam logic [15:0] PTR_RESET     = 16'h0000;
  localparam logic [15:0] UPDATE_ADDR   = 16'h0232;
  localparam int          UPDATE_BIT    = 0;

  // byte framing and buffering
  localparam logic [2:0]  LAST_BIT      = 3'h7;    // index of the eighth bit
  localparam int          FIFO_DEPTH    = 8;

  // one buffered register write
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        update;   // this byte sets the self-clearing update bit
  } wr_word_t;

  // bit-level sequencer
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_DECIDE, ST_ACK, ST_TX, ST_TXEND, ST_MACK, ST_MWAIT
  } state_t;

  // meaning of the next received byte
  typedef enum logic [1:0] {
    PH_DEV, PH_REGHI, PH_REGLO, PH_DATA
  } phase_t;

endpackage : i2c_slave_pkg

//--- sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             s_valid,
  output logic                  s_ready,
  input  wire logic [WIDTH-1:0] s_data,
  output logic                  m_valid,
  input  wire logic             m_ready,
  output logic      [WIDTH-1:0] m_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;
  logic [AW-1:0]    nxt_rptr;
  logic [AW:0]      nxt_count;
  logic             valid_ff;
  logic [WIDTH-1:0] head_ff;

  assign push      = s_valid && s_ready;
  assign pop       = m_valid && m_ready;
  assign s_ready   = (count_ff != (AW+1)'(DEPTH));   // honest full
  assign nxt_rptr  = pop ? ((rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1) : rptr_ff;
  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign m_valid   = valid_ff;                       // registered, so the outputs come from flops
  assign m_data    = head_ff;

  // not-empty flag, registered from the next fill level so it tracks count_ff
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= (nxt_count != '0);
    end
  end

  // head word; a word pushed straight into the head slot bypasses the array
  always_ff @(posedge sys_clk) begin
    if (push && (wptr_ff == nxt_rptr)) begin
      head_ff <= s_data;
    end else begin
      head_ff <= mem_ff[nxt_rptr];
    end
  end

  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= s_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sync_fifo

`default_nettype wire

//--- i2c_reg_slave.sv
// two-wire slave port giving an external master access to the configuration registers
`timescale 1ns/1ps
`default_nettype none

module i2c_reg_slave
  import i2c_slave_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic [1:0] addr_select_pin_upper,
  input  wire logic [1:0] addr_select_pin_lower,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output wr_word_t        wr_word,
  output logic            rd_req,
  output logic     [15:0] rd_addr,
  input  wire logic [7:0] rd_data
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // next pointer value, wrapping at the top of the 16-bit space
  function automatic logic [15:0] step_ptr(input logic [15:0] p);
    step_ptr = p + 16'h0001;
  endfunction : step_ptr

  // strap pair to the three low address bits; bit 3 set means port disabled
  function automatic logic [3:0] strap_code(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] h;
    logic [3:0] l;
    h = (hi == PIN_HIGH) ? 4'h2 : (hi == PIN_OPEN) ? 4'h1 : 4'h0;
    l = (lo == PIN_HIGH) ? 4'h2 : (lo == PIN_OPEN) ? 4'h1 : 4'h0;
    strap_code = 4'(h * STRAP_LEVELS + l);
  endfunction : strap_code

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic       scl_q_ff;
  logic       sda_q_ff;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [6:0] own_addr_ff;
  logic       enabled_ff;
  state_t     state_ff;
  phase_t     phase_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] rx_byte;
  logic       last_rx_bit;
  logic       last_tx_bit;
  logic       ack_ok_ff;
  logic       read_ff;
  logic [15:0] ptr_ff;
  logic [7:0] tx_byte_ff;
  logic [7:0] tx_sh_ff;
  logic       rd_pend_ff;
  logic       push_ff;
  wr_word_t   push_word_ff;
  logic       fifo_s_ready;
  logic       master_ack;

  //////////////////////////////////////////////////////////////////////////////
  // bus condition detection

  // previous pin levels for edge and condition detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
    end
  end

  assign scl_rise    = scl_in && !scl_q_ff;
  assign scl_fall    = !scl_in && scl_q_ff;
  assign start_det   = scl_in && scl_q_ff && sda_q_ff && !sda_in;
  assign stop_det    = scl_in && scl_q_ff && !sda_q_ff && sda_in;
  assign rx_byte     = {shift_ff[6:0], sda_in};
  assign last_rx_bit = scl_rise && (state_ff == ST_RX) && (bit_cnt_ff == LAST_BIT);
  assign last_tx_bit = scl_rise && (state_ff == ST_TX) && (bit_cnt_ff == LAST_BIT);
  assign master_ack  = scl_rise && (state_ff == ST_MACK) && !sda_in;

  //////////////////////////////////////////////////////////////////////////////
  // slave address from straps

  // straps are caught while reset is held
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      own_addr_ff <= {ADDR_FIXED_HI,
                      3'(strap_code(addr_select_pin_upper, addr_select_pin_lower))};
      enabled_ff  <= (strap_code(addr_select_pin_upper, addr_select_pin_lower) != STRAP_OTHER);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit sequencer

  // start, stop and bit/byte framing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= '0;
    end else if (start_det) begin
      state_ff   <= ST_RX;
      bit_cnt_ff <= '0;
    end else if (stop_det) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: ;
        ST_RX: if (scl_rise) begin
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == LAST_BIT) begin
            state_ff <= ST_DECIDE;
          end
        end
        ST_DECIDE: if (scl_fall) begin
          state_ff <= ack_ok_ff ? ST_ACK : ST_IDLE;
        end
        ST_ACK: if (scl_fall) begin
          state_ff   <= read_ff ? ST_TX : ST_RX;
          bit_cnt_ff <= '0;
        end
        ST_TX: if (scl_rise) begin
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == LAST_BIT) begin
            state_ff <= ST_TXEND;
          end
        end
        ST_TXEND: if (scl_fall) begin
          state_ff <= ST_MACK;
        end
        ST_MACK: if (scl_rise) begin
          state_ff <= sda_in ? ST_IDLE : ST_MWAIT;
        end
        ST_MWAIT: if (scl_fall) begin
          state_ff   <= ST_TX;
          bit_cnt_ff <= '0;
        end
      endcase
    end
  end

  // receive shift register, msb first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_ff <= '0;
    end else if (start_det || stop_det) begin
      shift_ff <= '0;
    end else if (scl_rise && state_ff == ST_RX) begin
      shift_ff <= rx_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // byte meaning and acknowledge decision

  // phase of the transfer and the direction bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_ff  <= PH_DEV;
      ack_ok_ff <= 1'b0;
      read_ff   <= 1'b0;
    end else if (start_det || stop_det) begin
      phase_ff  <= PH_DEV;
      ack_ok_ff <= 1'b0;
    end else if (last_rx_bit) begin
      unique case (phase_ff)
        PH_DEV: begin
          ack_ok_ff <= enabled_ff && (rx_byte[7:1] == own_addr_ff);
          read_ff   <= rx_byte[0];
          phase_ff  <= PH_REGHI;
        end
        PH_REGHI: begin
          ack_ok_ff <= 1'b1;
          phase_ff  <= PH_REGLO;
        end
        PH_REGLO: begin
          ack_ok_ff <= 1'b1;
          phase_ff  <= PH_DATA;
        end
        PH_DATA: begin
          ack_ok_ff <= fifo_s_ready;        // refuse when buffer full
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register pointer

  // loaded by the two pointer bytes, stepped after each accepted or sent data byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_ff <= PTR_RESET;
    end else if (last_rx_bit && phase_ff == PH_REGHI) begin
      ptr_ff[15:8] <= rx_byte;
    end else if (last_rx_bit && phase_ff == PH_REGLO) begin
      ptr_ff[7:0] <= rx_byte;
    end else if (last_rx_bit && phase_ff == PH_DATA && fifo_s_ready) begin
      ptr_ff <= step_ptr(ptr_ff);
    end else if (last_tx_bit) begin
      ptr_ff <= step_ptr(ptr_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write path into the buffer

  // one buffered write per accepted data byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      push_ff      <= 1'b0;
      push_word_ff <= '0;
    end else begin
      push_ff <= last_rx_bit && phase_ff == PH_DATA && fifo_s_ready;
      if (last_rx_bit) begin
        push_word_ff.addr   <= ptr_ff;
        push_word_ff.data   <= rx_byte;
        push_word_ff.update <= (ptr_ff == UPDATE_ADDR) && rx_byte[UPDATE_BIT];
      end
    end
  end

  sync_fifo #(
    .WIDTH ($bits(wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .s_valid (push_ff),
    .s_ready (fifo_s_ready),
    .s_data  (push_word_ff),
    .m_valid (wr_valid),
    .m_ready (wr_ready),
    .m_data  (wr_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // fetch request after the read address byte and after each master acknowledge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_req     <= 1'b0;
      rd_addr    <= PTR_RESET;
      rd_pend_ff <= 1'b0;
      tx_byte_ff <= '0;
    end else begin
      rd_req     <= (last_rx_bit && phase_ff == PH_DEV && rx_byte[0] &&
                     enabled_ff && rx_byte[7:1] == own_addr_ff) || master_ack;
      rd_addr    <= ptr_ff;
      rd_pend_ff <= rd_req;
      if (rd_pend_ff) begin
        tx_byte_ff <= rd_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data line drive, open drain

  // drive changes only on clock fall; released on start, stop or refusal
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_oe_n <= 1'b1;
      sda_out  <= 1'b0;
      tx_sh_ff <= '0;
    end else if (start_det || stop_det) begin
      sda_oe_n <= 1'b1;
    end else if (scl_fall) begin
      unique case (state_ff)
        ST_DECIDE: sda_oe_n <= !ack_ok_ff;
        ST_ACK, ST_MWAIT: begin
          if (read_ff) begin
            sda_oe_n <= tx_byte_ff[7];
            tx_sh_ff <= {tx_byte_ff[6:0], 1'b1};
          end else begin
            sda_oe_n <= 1'b1;
          end
        end
        ST_TX: begin
          sda_oe_n <= tx_sh_ff[7];
          tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
        end
        ST_TXEND: sda_oe_n <= 1'b1;         // master owns the ack slot
        ST_MACK:  sda_oe_n <= 1'b1;
        default:  sda_oe_n <= 1'b1;
      endcase
    end
  end

  // the clock line has no driver here at all

endmodule : i2c_reg_slave

`default_nettype wire

//--- i2c_reg_slave_props.sv
// port-level assertions for the two-wire register slave
`timescale 1ns/1ps
`default_nettype none

module i2c_reg_slave_props
  import i2c_slave_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic [1:0]  addr_select_pin_upper,
  input wire logic [1:0]  addr_select_pin_lower,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire wr_word_t    wr_word,
  input wire logic        rd_req,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0]  rd_data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // line drive, framing and buffer handover
  AST_OD_LOW: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_OE_SCL_LOW: assert property ((sda_oe_n != $past(sda_oe_n)) |-> !scl_in)
    else $error("data drive moved while clock high");
  AST_ACK_SPAN: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*3])
    else $error("low drive shorter than a clock pulse");
  AST_FRAME_RELEASE: assert property ((scl_in && $past(scl_in) && sda_in != $past(sda_in)) |=> sda_oe_n [*8])
    else $error("data held after start or stop");
  AST_RD_PULSE: assert property (rd_req |-> scl_in ##1 !rd_req [*8])
    else $error("fetch not a lone pulse on clock high");
  AST_WR_HOLD: assert property ((wr_valid && !wr_ready) |=> (wr_valid && $stable(wr_word)))
    else $error("buffered word moved before taken");
  AST_UPD_FLAG: assert property (wr_valid |-> wr_word.update == (wr_word.addr == UPDATE_ADDR && wr_word.data[UPDATE_BIT]))
    else $error("update flag wrong");
  AST_STRAP_OFF: assert property ((addr_select_pin_upper == PIN_HIGH && addr_select_pin_lower == PIN_HIGH) |-> sda_oe_n)
    else $error("disabled port drove data");
endmodule : i2c_reg_slave_props

bind i2c_reg_slave i2c_reg_slave_props props_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .addr_select_pin_upper(addr_select_pin_upper), .addr_select_pin_lower(addr_select_pin_lower),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data)
);
`default_nettype wire

//--- i2c_master_model.sv
// behavioural bus master making clock and data toward the slave port
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  input  wire logic sys_clk,
  input  wire logic sda_wire,
  output var logic  scl,
  output var logic  sda_rel
);
  // bus idle: clock stands high, data released to its pull-up
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  // wait n cycles, land just after the edge
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : w

  // one clock pulse: data set while low, sampled mid-high
  task automatic pulse(input logic b, output logic s);
    sda_rel = b;
    w(2);
    scl = 1'b1;
    w(2);
    s = sda_wire;
    w(2);
    scl = 1'b0;
    w(2);
  endtask : pulse

  // data falls while clock high, also as repeated start
  task automatic start();
    sda_rel = 1'b1;
    w(2);
    scl = 1'b1;
    w(2);
    sda_rel = 1'b0;
    w(2);
    scl = 1'b0;
    w(2);
  endtask : start

  // data low during clock low, rises while clock high
  task automatic stop();
    sda_rel = 1'b0;
    w(2);
    scl = 1'b1;
    w(2);
    sda_rel = 1'b1;
    w(2);
  endtask : stop

  // eight bits msb first, then release for the answer
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // collect eight bits, then acknowledge or refuse the last
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(nack, s);
  endtask : rd_byte
endmodule : i2c_master_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the two-wire register slave port
`timescale 1ns/1ps
`default_nettype none

module tb
  import i2c_slave_pkg::*;
;
  localparam logic [6:0] DEV = {ADDR_FIXED_HI, 3'h5}; // straps open and high select code 5
  logic        sys_clk, rst_n, scl, sda_rel, sda_wire, sda_out, sda_oe_n, wr_valid, wr_ready, rd_req;
  logic [1:0]  sel_hi, sel_lo;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data = 8'h00;
  logic        fetch_q;
  logic [15:0] fetch_a;
  wr_word_t    wr_word;
  wr_word_t    got[$];
  int          num_errors = 0;
  int          check_count = 0;

  // open-drain wire with pull-up
  assign sda_wire = sda_rel & (sda_oe_n | sda_out);

  i2c_master_model m (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_rel(sda_rel));
  i2c_reg_slave uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_pin_upper(sel_hi), .addr_select_pin_lower(sel_lo), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] reg_val(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5a;
  endfunction : reg_val

  ////////////////////////////////////////
  // register space holds the fetched byte in the cycle after the fetch pulse, otherwise churns
  always @(posedge sys_clk) begin
    fetch_q = rd_req;
    fetch_a = rd_addr;
    #1;
    rd_data = fetch_q ? reg_val(fetch_a) : ~rd_data;
  end

  // record every word the buffer hands over
  always @(posedge sys_clk) if (rst_n && wr_valid && wr_ready) got.push_back(wr_word);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset(input logic [1:0] u, input logic [1:0] l);
    rst_n  = 1'b0;
    sel_hi = u;
    sel_lo = l;
    m.w(3);
    rst_n = 1'b1;
    m.w(2);
  endtask : do_reset

  task automatic wb(input logic [7:0] b, input logic exp_ack);
    logic a;
    m.wr_byte(b, a);
    chk(a, exp_ack);
  endtask : wb

  task automatic set_ptr(input logic [15:0] p);
    m.start();
    wb({DEV, 1'b0}, 1'b1);
    wb(p[15:8], 1'b1);
    wb(p[7:0], 1'b1);
  endtask : set_ptr

  task automatic rd_run(input logic [15:0] p, input int n);
    logic [7:0] d;
    m.start();
    wb({DEV, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rd_byte(1'(i == n - 1), d);
      chk(d, reg_val(p + 16'(i)));
    end
    m.stop();
  endtask : rd_run

  task automatic wr_run(input logic [15:0] p, input int n, input int acked);
    set_ptr(p);
    for (int i = 0; i < n; i++) wb(8'h31 + 8'(i), 1'(i < acked));
    m.stop();
  endtask : wr_run

  task automatic expect_got(input logic [15:0] p, input int k);
    logic [15:0] a;
    logic [7:0]  d;
    m.w(20);
    chk(got.size(), k);
    for (int i = 0; i < got.size(); i++) begin
      a = p + 16'(i);
      d = 8'h31 + 8'(i);
      chk(got[i], {a, d, (a == UPDATE_ADDR) && d[UPDATE_BIT]});
    end
    chk(wr_valid, 1'b0);
    got.delete();
  endtask : expect_got

  ////////////////////////////////////////
  task automatic t_write;
    wr_ready = 1'b1;
    wr_run(16'h0230, 3, 3);
    expect_got(16'h0230, 3);
  endtask : t_write

  // consumer stalls until the buffer refuses a byte
  task automatic t_full;
    wr_ready = 1'b0;
    wr_run(16'h0010, FIFO_DEPTH + 1, FIFO_DEPTH);
    chk(wr_valid, 1'b1);
    wr_ready = 1'b1;
    expect_got(16'h0010, FIFO_DEPTH);
  endtask : t_full

  task automatic t_send_read;
    set_ptr(16'h1234);
    m.stop();
    m.w(10);
    chk(got.size(), 0);
    rd_run(16'h1234, 3);
  endtask : t_send_read

  task automatic t_combined;
    set_ptr(16'h00ff);
    rd_run(16'h00ff, 2);
    rd_run(16'h0101, 1);
  endtask : t_combined

  task automatic t_wrong;
    m.start();
    wb({DEV ^ 7'h01, 1'b0}, 1'b0);
    m.stop();
    m.start();
    wb({DEV ^ 7'h40, 1'b1}, 1'b0);
    m.stop();
    chk(got.size(), 0);
  endtask : t_wrong

  // start and stop in mid-byte drop the partial bits
  task automatic t_abort;
    logic s;
    m.start();
    wb({DEV, 1'b0}, 1'b1);
    repeat (4) m.pulse(1'b0, s);
    set_ptr(16'h0040);
    repeat (3) m.pulse(1'b1, s);
    m.stop();
    m.w(10);
    chk(got.size(), 0);
    rd_run(16'h0040, 1);
  endtask : t_abort

  task automatic t_straps;
    for (int u = 0; u < 3; u++) begin
      for (int l = 0; l < 3; l++) begin
        do_reset(2'(u), 2'(l));
        m.start();
        wb({ADDR_FIXED_HI, 3'(u * 3 + l), 1'b0}, 1'(!(u == 2 && l == 2)));
        m.stop();
      end
    end
  endtask : t_straps

  ////////////////////////////////////////
  initial begin
    rst_n    = 1'b0;
    sel_hi   = PIN_OPEN;
    sel_lo   = PIN_HIGH;
    wr_ready = 1'b0;
    do_reset(PIN_OPEN, PIN_HIGH);
    t_write;
    t_full;
    t_send_read;
    t_combined;
    t_wrong;
    t_abort;
    t_straps;
    wrap_up;
  end

  // watchdog against a hung bus
  initial begin
    #200us;
    num_errors++;
    wrap_up;
  end
endmodule : tb
`default_nettype wire
